/* core/ccs_err_if.sv */
// Purpose: Link between register bank and error measurement engine
// Assumes: Single clock domain
// Notes: Start is a one-cycle pulse
`default_nettype none

interface ccs_err_if;
  logic start;
  logic [2:0] bits_sel;
  logic done;
  logic [39:0] err_count;
  modport bank (output start, output bits_sel, input done, input err_count);
  modport meter (input start, input bits_sel, output done, output err_count);
endinterface : ccs_err_if

`default_nettype wire

/* core/ccs_err_meter.sv */
// Purpose: Counts bit errors over a selected number of received bits
// Assumes: bit_tick and bit_error are one-cycle pulses per recovered bit
// Notes: Count stays readable after the run until the next start
`default_nettype none

module ccs_err_meter
  import ccs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic bit_error,
  ccs_err_if.meter link
);
  ccs_err_state_t state_reg;
  logic [ERR_W-1:0] bits_reg;
  logic [ERR_W-1:0] errs_reg;
  logic done_reg;
  logic [ERR_W-1:0] last_bit;

  // Last bit index of a run of 2^(18+3k) bits
  function automatic logic [ERR_W-1:0] run_last(input logic [2:0] sel);
    logic [ERR_W-1:0] one;
    one = {{(ERR_W-1){1'b0}}, 1'b1};
    run_last = (one << (BITS_BASE_EXP + BITS_STEP_EXP * int'(sel))) - one;
  endfunction : run_last

  assign last_bit = run_last(link.bits_sel);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= CCS_ERR_IDLE;
      done_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        CCS_ERR_IDLE: begin
          if (link.start) begin
            state_reg <= CCS_ERR_RUN; // RL15
            done_reg <= 1'b0;
          end
        end
        CCS_ERR_RUN: begin
          if (bit_tick && bits_reg == last_bit) begin
            state_reg <= CCS_ERR_IDLE;
            done_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= CCS_ERR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bits_reg <= '0;
      errs_reg <= '0;
    end else if (link.start && state_reg == CCS_ERR_IDLE) begin
      bits_reg <= '0;
      errs_reg <= '0;
    end else if (state_reg == CCS_ERR_RUN && bit_tick) begin
      bits_reg <= bits_reg + 1'b1;
      // Saturate rather than wrap on a hopeless link
      if (bit_error && errs_reg != {ERR_W{1'b1}}) begin
        errs_reg <= errs_reg + 1'b1;
      end
    end
  end

  assign link.done = done_reg;
  assign link.err_count = errs_reg;
endmodule : ccs_err_meter

`default_nettype wire

/* core/ccs_pkg.sv */
// Purpose: Constants for the recovery receiver control/status register bank
// Assumes: Byte-wide register port fed by an external serial management slave
// Notes: Offsets are byte addresses of that port
//
// Behaviour
// RL1 - Status bit 5 reads 1 while input signal absent, else 0.
// RL2 - Status bit 4 latches on lock loss, holds until cleared.
// RL3 - Status bit 2 reads 0 while measuring rate, 1 when finished.
// RL4 - Status bit 3 reads 0 when loop locked, 1 while acquiring.
// RL5 - Rate control bit 0 set locks loop to reference clock, else data.
// RL6 - Host writes 1 into rate control bit 1 to start measurement.
// RL7 - Lock detect bit 7 set: lock-lost pin shows latched flag, else live.
// RL8 - Writing 1 then 0 to lock detect bit 6 clears status bit 4.
// RL9 - Writing 1 then 0 to lock detect bit 3 clears status bit 2.
// RL10 - Signal detect bit 1: 0 squelches both outputs, 1 each independently.
// RL11 - Three-bit byte select picks one of five error count bytes.
// RL12 - Read-only register returns error monitor converter input, low six bits.
// RL13 - Phase trim is six-bit two's complement, valid -30 to +30.
// RL14 - Each phase step moves sampling by one sixtieth unit interval.
// RL15 - Writing 1 then 0 to error control bit 3 starts one measurement.
// RL16 - Nine-bit rate bounds join eight high bits and one shared low bit. Code takes bit 1 of 0x39 for upper, bit 0 for lower.
// RL17 - Host writes zero into every reserved or must-be-zero control bit.
`default_nettype none

package ccs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_RATE_B0 = 8'h00;
  localparam logic [7:0] ADDR_RATE_B1 = 8'h01;
  localparam logic [7:0] ADDR_RATE_B2 = 8'h02;
  localparam logic [7:0] ADDR_COARSE = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RATE_CTL_RD = 8'h05;
  localparam logic [7:0] ADDR_LOCK_CTL_RD = 8'h06;
  localparam logic [7:0] ADDR_RATE_CTL = 8'h08;
  localparam logic [7:0] ADDR_LOCK_CTL = 8'h09;
  localparam logic [7:0] ADDR_SIG_CFG = 8'h11;
  localparam logic [7:0] ADDR_ERR_CTL = 8'h1e;
  localparam logic [7:0] ADDR_ERR_DONE = 8'h20;
  localparam logic [7:0] ADDR_ERR_BYTE = 8'h21;
  localparam logic [7:0] ADDR_ERR_LEVEL = 8'h24;
  localparam logic [7:0] ADDR_SEL_MODE = 8'h34;
  localparam logic [7:0] ADDR_UPPER = 8'h35;
  localparam logic [7:0] ADDR_LOWER = 8'h36;
  localparam logic [7:0] ADDR_PHASE = 8'h37;
  localparam logic [7:0] ADDR_BOUND_LSB = 8'h39;
  // Field positions
  localparam int ST_ABSENT = 5;
  localparam int ST_LATCHED = 4;
  localparam int ST_ACQUIRE = 3;
  localparam int ST_RATE_DONE = 2;
  localparam int RC_REF_LOCK = 0;
  localparam int RC_MEASURE = 1;
  localparam int LC_STATIC = 7;
  localparam int LC_CLR_LATCH = 6;
  localparam int LC_FREQ_ACQ = 5;
  localparam int LC_CLR_DONE = 3;
  localparam int SC_LOS_POL = 2;
  localparam int SC_SQUELCH = 1;
  localparam int EC_START = 3;
  localparam int EC_BITS_LO = 5;
  localparam int SM_LIMITED = 3;
  localparam int SM_HOLDOVER = 1;
  localparam int BL_UPPER = 1;
  localparam int BL_LOWER = 0;
  // Widths, limits and reset value
  localparam int ERR_W = 40;
  localparam int ERR_BYTES = 5;
  localparam int BITS_BASE_EXP = 18;
  localparam int BITS_STEP_EXP = 3;
  localparam logic signed [5:0] PHASE_MAX = 6'sd30;
  localparam logic signed [5:0] PHASE_MIN = -6'sd30;
  localparam int PHASE_STEPS_PER_UI = 60;
  localparam logic [7:0] CTL_RESET = 8'h00;

  typedef enum logic [1:0] {
    CCS_ERR_IDLE = 2'b01,
    CCS_ERR_RUN = 2'b10
  } ccs_err_state_t;
endpackage : ccs_pkg

`default_nettype wire

/* core/ccs_regs.sv */
// Purpose: Control and status register bank of the recovery receiver
// Assumes: Byte register port driven by a serial management slave
// Notes: Pulse-type actions fire on the 1-then-0 write sequence, except rate start, which fires on any write of 1
`default_nettype none

module ccs_regs
  import ccs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Receiver state
  input wire logic signal_absent,
  input wire logic loop_acquiring,
  input wire logic rate_meas_finished,
  input wire logic [23:0] measured_rate,
  input wire logic [8:0] coarse_rate,
  input wire logic [5:0] err_mon_level,
  input wire logic bit_tick,
  input wire logic bit_error,
  // Controls to the analogue side
  output logic lock_to_reference,
  output logic rate_meas_start,
  output logic freq_acq_start,
  output logic [5:0] ref_ratio,
  output logic [1:0] ref_range,
  output logic squelch_independent,
  output logic signal_absent_pin,
  output logic lock_lost_pin,
  output logic limited_rate_en,
  output logic holdover_en,
  output logic [8:0] upper_rate_bound,
  output logic [8:0] lower_rate_bound,
  output logic [5:0] sample_phase_code
);
  ccs_err_if err_link ();

  logic [7:0] rate_ctl_reg;
  logic [7:0] lock_ctl_reg;
  logic [7:0] sig_cfg_reg;
  logic [7:0] err_ctl_reg;
  logic [7:0] sel_mode_reg;
  logic [7:0] upper_reg;
  logic [7:0] lower_reg;
  logic [7:0] phase_reg;
  logic [7:0] bound_lsb_reg;
  logic latched_loss_reg;
  logic acquiring_prev_reg;
  logic rate_done_reg;
  logic rate_start_reg;
  logic freq_start_reg;
  logic err_start_reg;
  logic [7:0] rdata_reg;
  logic lol_pin_reg;
  logic los_pin_reg;
  logic [5:0] phase_out_reg;
  logic [8:0] upper_out_reg;
  logic [8:0] lower_out_reg;
  logic [7:0] status_next;
  logic [7:0] rdata_next;
  logic loss_event;
  logic clr_latch;
  logic clr_rate_done;

  // True on a write to the given address
  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = wr && (a == target);
  endfunction : wr_hit

  // True when a write drops a bit that was stored as 1
  function automatic logic falls(input logic hit, input logic old_bit,
                                 input logic new_bit);
    falls = hit && old_bit && !new_bit;
  endfunction : falls

  // Limit a phase code to the usable span
  function automatic logic [5:0] clamp_phase(input logic [5:0] code);
    logic signed [5:0] s;
    s = signed'(code);
    if (s > PHASE_MAX) begin
      clamp_phase = PHASE_MAX;
    end else if (s < PHASE_MIN) begin
      clamp_phase = PHASE_MIN;
    end else begin
      clamp_phase = code;
    end
  endfunction : clamp_phase

  ////////////////////////////////////////////////////////////////////////
  // Write-only control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_ctl_reg <= CTL_RESET;
      lock_ctl_reg <= CTL_RESET;
      sig_cfg_reg <= CTL_RESET;
      err_ctl_reg <= CTL_RESET;
    end else begin
      if (wr_hit(reg_wr, reg_addr, ADDR_RATE_CTL)) begin
        rate_ctl_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_LOCK_CTL)) begin
        lock_ctl_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_SIG_CFG)) begin
        sig_cfg_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_ERR_CTL)) begin
        err_ctl_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sel_mode_reg <= CTL_RESET;
      upper_reg <= CTL_RESET;
      lower_reg <= CTL_RESET;
      phase_reg <= CTL_RESET;
      bound_lsb_reg <= CTL_RESET;
    end else begin
      if (wr_hit(reg_wr, reg_addr, ADDR_SEL_MODE)) begin
        sel_mode_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_UPPER)) begin
        upper_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_LOWER)) begin
        lower_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_PHASE)) begin
        phase_reg <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, ADDR_BOUND_LSB)) begin
        bound_lsb_reg <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-sequence actions
  assign clr_latch = falls(wr_hit(reg_wr, reg_addr, ADDR_LOCK_CTL),
                           lock_ctl_reg[LC_CLR_LATCH], reg_wdata[LC_CLR_LATCH]); // RL8
  assign clr_rate_done = falls(wr_hit(reg_wr, reg_addr, ADDR_LOCK_CTL),
                               lock_ctl_reg[LC_CLR_DONE], reg_wdata[LC_CLR_DONE]); // RL9

  // Every write with the measure bit set counts as a fresh request
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_start_reg <= 1'b0;
    end else begin
      rate_start_reg <= wr_hit(reg_wr, reg_addr, ADDR_RATE_CTL) && reg_wdata[RC_MEASURE]; // RL6
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      freq_start_reg <= 1'b0;
    end else begin
      freq_start_reg <= falls(wr_hit(reg_wr, reg_addr, ADDR_LOCK_CTL),
                              lock_ctl_reg[LC_FREQ_ACQ], reg_wdata[LC_FREQ_ACQ]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      err_start_reg <= 1'b0;
    end else begin
      err_start_reg <= falls(wr_hit(reg_wr, reg_addr, ADDR_ERR_CTL),
                             err_ctl_reg[EC_START], reg_wdata[EC_START]); // RL15
    end
  end

  assign err_link.start = err_start_reg;
  assign err_link.bits_sel = err_ctl_reg[EC_BITS_LO +: 3];

  ccs_err_meter u_meter (
    .clock(clock),
    .rst(rst),
    .bit_tick(bit_tick),
    .bit_error(bit_error),
    .link(err_link)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status flags
  assign loss_event = loop_acquiring && !acquiring_prev_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      acquiring_prev_reg <= 1'b0;
    end else begin
      acquiring_prev_reg <= loop_acquiring;
    end
  end

  // A loss in the clearing cycle still sets the flag
  always_ff @(posedge clock) begin
    if (rst) begin
      latched_loss_reg <= 1'b0;
    end else if (loss_event) begin
      latched_loss_reg <= 1'b1; // RL2
    end else if (clr_latch) begin
      latched_loss_reg <= 1'b0; // RL8
    end
  end

  // Done drops when a measurement starts, rises when it ends
  always_ff @(posedge clock) begin
    if (rst) begin
      rate_done_reg <= 1'b0;
    end else if (rate_meas_finished) begin
      rate_done_reg <= 1'b1; // RL3
    end else if (rate_start_reg || clr_rate_done) begin
      rate_done_reg <= 1'b0; // RL9
    end
  end

  always_comb begin
    status_next = 8'h00;
    status_next[ST_ABSENT] = signal_absent; // RL1
    status_next[ST_LATCHED] = latched_loss_reg; // RL2
    status_next[ST_ACQUIRE] = loop_acquiring; // RL4
    status_next[ST_RATE_DONE] = rate_done_reg; // RL3
    status_next[0] = coarse_rate[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; write-only and unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      ADDR_RATE_B0: rdata_next = measured_rate[7:0];
      ADDR_RATE_B1: rdata_next = measured_rate[15:8];
      ADDR_RATE_B2: rdata_next = measured_rate[23:16];
      ADDR_COARSE: rdata_next = coarse_rate[8:1];
      ADDR_STATUS: rdata_next = status_next;
      ADDR_RATE_CTL_RD: rdata_next = rate_ctl_reg;
      ADDR_LOCK_CTL_RD: rdata_next = lock_ctl_reg;
      ADDR_ERR_DONE: rdata_next = {7'h00, err_link.done};
      ADDR_ERR_BYTE: rdata_next = err_link.err_count[8*int'(err_ctl_reg[2:0]) +: 8]; // RL11
      ADDR_ERR_LEVEL: rdata_next = {2'b00, err_mon_level}; // RL12
      default: rdata_next = 8'h00;
    endcase
    // Codes above the fifth byte read zero
    if (reg_addr == ADDR_ERR_BYTE && int'(err_ctl_reg[2:0]) >= ERR_BYTES) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin and analogue control outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      lol_pin_reg <= 1'b0;
      los_pin_reg <= 1'b0;
    end else begin
      lol_pin_reg <= lock_ctl_reg[LC_STATIC] ? latched_loss_reg : loop_acquiring; // RL7
      // Polarity select lets the pin match either board convention
      los_pin_reg <= sig_cfg_reg[SC_LOS_POL] ? !signal_absent : signal_absent;
    end
  end

  // Out-of-span codes are clamped so the sampler never leaves the eye span
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_out_reg <= 6'h00;
    end else begin
      phase_out_reg <= clamp_phase(phase_reg[5:0]); // RL13 RL14
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      upper_out_reg <= 9'h000;
      lower_out_reg <= 9'h000;
    end else begin
      upper_out_reg <= {upper_reg, bound_lsb_reg[BL_UPPER]}; // RL16
      lower_out_reg <= {lower_reg, bound_lsb_reg[BL_LOWER]}; // RL16
    end
  end

  assign reg_rdata = rdata_reg;
  assign lock_to_reference = rate_ctl_reg[RC_REF_LOCK]; // RL5
  assign rate_meas_start = rate_start_reg;
  assign freq_acq_start = freq_start_reg;
  assign ref_ratio = rate_ctl_reg[7:2] & 6'h0f;
  assign ref_range = rate_ctl_reg[7:6];
  assign squelch_independent = sig_cfg_reg[SC_SQUELCH]; // RL10
  assign signal_absent_pin = los_pin_reg;
  assign lock_lost_pin = lol_pin_reg;
  assign limited_rate_en = sel_mode_reg[SM_LIMITED];
  assign holdover_en = sel_mode_reg[SM_HOLDOVER];
  assign upper_rate_bound = upper_out_reg;
  assign lower_rate_bound = lower_out_reg;
  assign sample_phase_code = phase_out_reg;
endmodule : ccs_regs

`default_nettype wire

/* sim/ccs_regs_chk.sv */
// Purpose: Port-level checks for the recovery receiver register bank
// Assumes: Single clock, bound onto ccs_regs
// Notes: Mirrors only the lock-detect pin mode bit
`default_nettype none

module ccs_regs_chk
  import ccs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic signal_absent,
  input wire logic loop_acquiring,
  input wire logic [5:0] err_mon_level,
  input wire logic lock_to_reference,
  input wire logic rate_meas_start,
  input wire logic squelch_independent,
  input wire logic lock_lost_pin,
  input wire logic [8:0] upper_rate_bound,
  input wire logic [5:0] sample_phase_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic static_q;
  logic wr_rate;
  logic wr_up;
  assign wr_rate = reg_wr && (reg_addr == ADDR_RATE_CTL);
  assign wr_up = reg_wr && (reg_addr == ADDR_UPPER);

  always_ff @(posedge clock) begin
    if (rst) begin
      static_q <= 1'b0;
    end else if (reg_wr && (reg_addr == ADDR_LOCK_CTL)) begin
      static_q <= reg_wdata[LC_STATIC];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_start; rate_meas_start == $past(wr_rate && reg_wdata[RC_MEASURE]); endproperty
  property p_ref; wr_rate |=> lock_to_reference == $past(reg_wdata[RC_REF_LOCK]); endproperty
  property p_sq;
    (reg_wr && reg_addr == ADDR_SIG_CFG) |=> squelch_independent == $past(reg_wdata[SC_SQUELCH]);
  endproperty
  property p_status;
    (reg_rd && reg_addr == ADDR_STATUS) |=>
      reg_rdata[ST_ABSENT] == $past(signal_absent) && reg_rdata[ST_ACQUIRE] == $past(loop_acquiring);
  endproperty
  property p_latch; (static_q && $rose(loop_acquiring)) |-> ##[1:3] lock_lost_pin; endproperty
  property p_live; (!static_q && !$past(static_q)) |-> lock_lost_pin == $past(loop_acquiring); endproperty
  property p_bound; wr_up ##1 !wr_up |=> upper_rate_bound[8:1] == $past(reg_wdata, 2); endproperty
  property p_phase;
    $signed(sample_phase_code) <= PHASE_MAX && $signed(sample_phase_code) >= PHASE_MIN;
  endproperty
  property p_level; (reg_rd && reg_addr == ADDR_ERR_LEVEL) |=> reg_rdata[5:0] == $past(err_mon_level); endproperty

  a_start: assert property (p_start) else $error("rate start pulse wrong");
  a_ref: assert property (p_ref) else $error("reference lock bit wrong");
  a_sq: assert property (p_sq) else $error("squelch mode wrong");
  a_status: assert property (p_status) else $error("status read wrong");
  a_latch: assert property (p_latch) else $error("latched lock loss not shown");
  a_live: assert property (p_live) else $error("live lock pin wrong");
  a_bound: assert property (p_bound) else $error("upper bound high bits wrong");
  a_phase: assert property (p_phase) else $error("phase code out of range");
  a_level: assert property (p_level) else $error("monitor level read wrong");

  c_latch: cover property (static_q && $rose(loop_acquiring));
  c_start: cover property (rate_meas_start);
  c_level: cover property (reg_rd && reg_addr == ADDR_ERR_LEVEL);
endmodule : ccs_regs_chk

bind ccs_regs ccs_regs_chk u_chk (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .signal_absent(signal_absent),
  .loop_acquiring(loop_acquiring), .err_mon_level(err_mon_level), .lock_to_reference(lock_to_reference),
  .rate_meas_start(rate_meas_start), .squelch_independent(squelch_independent),
  .lock_lost_pin(lock_lost_pin), .upper_rate_bound(upper_rate_bound), .sample_phase_code(sample_phase_code));

`default_nettype wire

/* sim/ccs_rx_model.sv */
// Purpose: Received bit stream source feeding the error meter inputs
// Assumes: One recovered bit per clock while enabled
// Notes: Every fourth bit is flagged wrong
`default_nettype none

module ccs_rx_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  output logic bit_tick,
  output logic bit_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] n_reg;

  always_ff @(posedge clock) begin
    if (rst || !en) begin
      n_reg <= 2'h0;
      bit_tick <= 1'b0;
      bit_error <= 1'b0;
    end else begin
      n_reg <= n_reg + 2'h1;
      bit_tick <= 1'b1;
      bit_error <= (n_reg == 2'h3);
    end
  end
endmodule : ccs_rx_model

`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Strobe register port, inputs driven on falling edges
// Notes: Error runs cannot finish within the cycle budget; the start and the partial error count are checked
`default_nettype none

module tb_top;
  import ccs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, reg_wr, reg_rd, signal_absent, loop_acquiring, rate_meas_finished, rx_en;
  logic bit_tick, bit_error, lock_to_reference, squelch_independent, lock_lost_pin;
  logic rate_meas_start, freq_acq_start, signal_absent_pin, limited_rate_en, holdover_en;
  logic [1:0] ref_range;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
  logic [5:0] err_mon_level, sample_phase_code, ref_ratio;
  logic [8:0] upper_rate_bound, lower_rate_bound;
  logic [7:0] ph_in [4] = '{8'h3a, 8'h1e, 8'h20, 8'h1f};
  logic [5:0] ph_exp [4] = '{6'h3a, 6'h1e, 6'h22, 6'h1e};
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  ccs_regs dut (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .signal_absent(signal_absent),
    .loop_acquiring(loop_acquiring), .rate_meas_finished(rate_meas_finished), .measured_rate(24'h00_0000),
    .coarse_rate(9'h000), .err_mon_level(err_mon_level), .bit_tick(bit_tick), .bit_error(bit_error),
    .lock_to_reference(lock_to_reference), .rate_meas_start(rate_meas_start), .freq_acq_start(freq_acq_start),
    .ref_ratio(ref_ratio), .ref_range(ref_range), .squelch_independent(squelch_independent),
    .signal_absent_pin(signal_absent_pin), .lock_lost_pin(lock_lost_pin), .limited_rate_en(limited_rate_en),
    .holdover_en(holdover_en), .upper_rate_bound(upper_rate_bound),
    .lower_rate_bound(lower_rate_bound), .sample_phase_code(sample_phase_code));
  ccs_rx_model u_rx (.clock(clock), .rst(rst), .en(rx_en), .bit_tick(bit_tick), .bit_error(bit_error));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  // One idle cycle, then strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    rdv = reg_rdata;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_wr, reg_rd, signal_absent, loop_acquiring, rate_meas_finished, rx_en} = 7'b1000000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_mon_level = 6'h00;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    rd(ADDR_RATE_CTL_RD); chk("rate ctl reset", 9'(rdv), 9'(CTL_RESET));
    signal_absent = 1'b1;
    rd(ADDR_STATUS); chk("absent", 9'(rdv[5]), 9'h001);
    chk("locked", 9'(rdv[3]), 9'h000);
    chk("absent pin", 9'(signal_absent_pin), 9'h001);
    signal_absent = 1'b0;
    loop_acquiring = 1'b1;
    idle(3);
    rd(ADDR_STATUS); chk("present", 9'(rdv[5]), 9'h000);
    chk("acquiring", 9'(rdv[3]), 9'h001);
    chk("latched", 9'(rdv[4]), 9'h001);
    loop_acquiring = 1'b0;
    wr(ADDR_LOCK_CTL, 8'h80); idle(2);
    chk("pin static", 9'(lock_lost_pin), 9'h001);
    rd(ADDR_LOCK_CTL_RD); chk("lock ctl rb", 9'(rdv), 9'h080);
    rd(ADDR_STATUS); chk("held", 9'(rdv[4]), 9'h001);
    wr(ADDR_LOCK_CTL, 8'hc0);
    wr(ADDR_LOCK_CTL, 8'h80); idle(2);
    rd(ADDR_STATUS); chk("cleared", 9'(rdv[4]), 9'h000);
    chk("pin cleared", 9'(lock_lost_pin), 9'h000);
    loop_acquiring = 1'b1;
    idle(4);
    chk("pin relatched", 9'(lock_lost_pin), 9'h001);
    loop_acquiring = 1'b0;
    wr(ADDR_LOCK_CTL, 8'h20);
    wr(ADDR_LOCK_CTL, 8'h00);
    chk("freq acq pulse", 9'(freq_acq_start), 9'h001);
    idle(2);
    chk("pin live", 9'(lock_lost_pin), 9'h000);
    // Rate measurement start, finish and clear
    wr(ADDR_RATE_CTL, 8'h02);
    chk("rate start", 9'(rate_meas_start), 9'h001);
    idle(2);
    rd(ADDR_STATUS); chk("measuring", 9'(rdv[2]), 9'h000);
    rate_meas_finished = 1'b1;
    idle(1);
    rate_meas_finished = 1'b0;
    rd(ADDR_STATUS); chk("rate done", 9'(rdv[2]), 9'h001);
    wr(ADDR_LOCK_CTL, 8'h08);
    wr(ADDR_LOCK_CTL, 8'h00);
    rd(ADDR_STATUS); chk("done cleared", 9'(rdv[2]), 9'h000);
    wr(ADDR_RATE_CTL, 8'h8d); idle(1);
    chk("ref lock", 9'(lock_to_reference), 9'h001);
    chk("ref ratio", 9'(ref_ratio), 9'h003);
    chk("ref range", 9'(ref_range), 9'h002);
    wr(ADDR_RATE_CTL, 8'h00); idle(1);
    chk("data lock", 9'(lock_to_reference), 9'h000);
    wr(ADDR_SIG_CFG, 8'h06); idle(1);
    chk("squelch split", 9'(squelch_independent), 9'h001);
    chk("absent pin low", 9'(signal_absent_pin), 9'h001);
    wr(ADDR_SIG_CFG, 8'h00); idle(1);
    chk("squelch joint", 9'(squelch_independent), 9'h000);
    chk("absent pin high", 9'(signal_absent_pin), 9'h000);
    wr(ADDR_SEL_MODE, 8'h0a); idle(1);
    chk("limited rate", 9'(limited_rate_en), 9'h001);
    chk("holdover", 9'(holdover_en), 9'h001);
    wr(ADDR_UPPER, 8'ha5);
    wr(ADDR_LOWER, 8'h3c);
    wr(ADDR_BOUND_LSB, 8'h02); idle(2);
    chk("upper", upper_rate_bound, 9'h14b);
    chk("lower", lower_rate_bound, 9'h078);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PHASE, ph_in[i]); idle(2);
      chk("phase", 9'(sample_phase_code), 9'(ph_exp[i]));
    end
    err_mon_level = 6'h2b;
    rd(ADDR_ERR_LEVEL); chk("level", 9'(rdv[5:0]), 9'h02b);
    // 1200 bits after the start, every fourth wrong: 300 errors
    wr(ADDR_ERR_CTL, 8'h08);
    wr(ADDR_ERR_CTL, 8'h00);
    rx_en = 1'b1;
    idle(1200);
    rx_en = 1'b0;
    idle(2);
    rd(ADDR_ERR_DONE); chk("run not done", 9'(rdv[0]), 9'h000);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_ERR_CTL, 8'(s));
      rd(ADDR_ERR_BYTE); chk("count byte", 9'(rdv), (s == 0) ? 9'h02c : (s == 1) ? 9'h001 : 9'h000);
    end
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
